// [hdl/isp_defines.vh]
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ISP_OFS_SYSCTL      8'h00
`define ISP_OFS_SENSE       8'h04
`define ISP_OFS_ENABLE      8'h08
`define ISP_OFS_FLAGS       8'h0C
`define ISP_OFS_PRI_BASE    8'h10
`define ISP_OFS_PRI_LAST    8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ISP_BIT_NMI_EDGE    0
`define ISP_BIT_CTRL_MODE   1
`define ISP_BIT_NMI_PEND    7
`define ISP_PRI_HI_LSB      4
`define ISP_PRI_LO_LSB      0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ISP_RST_SENSE       12'h000
`define ISP_RST_ENABLE      6'h00
`define ISP_RST_FLAGS       6'h00
`define ISP_RST_PRI         3'h7

// ----------------------------------------------------------------
// sense encodings and vectors
// ----------------------------------------------------------------
`define ISP_SENSE_LOW       2'h0
`define ISP_SENSE_FALL      2'h1
`define ISP_SENSE_RISE      2'h2
`define ISP_SENSE_BOTH      2'h3
`define ISP_VEC_NMI         7'h07
`define ISP_VEC_PIN0        7'h10
`define ISP_LVL_NMI         3'h7

`endif

// [hdl/isp_pin_detect.v]
`include "isp_defines.vh"

module isp_pin_detect (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       pin_in,
	input  wire [1:0] sense_in,
	output reg        event_out,
	output wire       level_out
);

	reg sync1_ff;
	reg sync2_ff;
	reg prev_ff;

	// ----------------------------------------------------------------
	// synchroniser, idle level high
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff  <= 1'b1;
		end else begin
			sync1_ff <= pin_in; // [RQ21]
			sync2_ff <= sync1_ff; // [RQ21]
			prev_ff  <= sync2_ff;
		end
	end

	assign level_out = sync2_ff;

	// ----------------------------------------------------------------
	// sense decode, edges judged on synced copies only
	// ----------------------------------------------------------------
	always @* begin
		case (sense_in) // [RQ17]
			`ISP_SENSE_LOW:  event_out = ~sync2_ff; // [RQ5]
			`ISP_SENSE_FALL: event_out = prev_ff & ~sync2_ff; // [RQ5]
			`ISP_SENSE_RISE: event_out = ~prev_ff & sync2_ff; // [RQ5]
			`ISP_SENSE_BOTH: event_out = prev_ff ^ sync2_ff; // [RQ5]
			default:         event_out = 1'b0;
		endcase
	end

endmodule

// [hdl/isp_top.v]
// Overview of operation
// (RQ1) one nonmaskable plus six maskable pin inputs
// (RQ2) any pin event raises the wake output
// (RQ3) nonmaskable request wins, ignores every mask
// (RQ4) control bit picks nonmaskable rising or falling
// (RQ5) per pin: low, falling, rising, both edges
// (RQ6) pin request forwarded only while enabled
// (RQ7) each pin has sticky flag, cleared by 0
// (RQ8) detection ignores the pin's port direction
// (RQ9) peripheral request needs flag and enable both
// (RQ10) peripheral transfer start ignores all masks
// (RQ11) three-bit priority field per module
// (RQ12) default order: lower vector number wins
// (RQ13) equal levels fall back to vector order
// (RQ14) sources inside a module keep fixed order
// (RQ15) vector address is vector number times four
// (RQ16) vectors 22, 23, 103 never produced; pins 16-21
// (RQ17) sense codes 00 low, 01 fall, 10 rise, 11 both
// (RQ18) flag clear needs read of 1 first
// (RQ19) acceptance clears edge flags; level only if high
// (RQ20) eight-level mode needs level above mask
// (RQ21) pins pass two flip-flops before detection
// (RQ22) reset: all zero, priorities at default
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`include "isp_defines.vh"

module isp_top #(
	parameter NUM_PER = 10,
	parameter [7*NUM_PER-1:0] PER_VEC = {7'h24, 7'h23, 7'h22, 7'h21, 7'h20,
	                                     7'h1D, 7'h1C, 7'h1B, 7'h19, 7'h18},
	parameter [4*NUM_PER-1:0] PER_FLD = {4'hA, 4'hA, 4'hA, 4'hA, 4'hA,
	                                     4'h9, 4'h9, 4'h8, 4'h6, 4'h5}
) (
	input  wire                 ref_clk_in,
	input  wire                 rstn_in,
	input  wire [7:0]           avs_address_in,
	input  wire                 avs_read_in,
	input  wire                 avs_write_in,
	input  wire [31:0]          avs_writedata_in,
	input  wire [3:0]           avs_byteenable_in,
	output reg  [31:0]          avs_readdata_out,
	output reg                  avs_waitrequest_out,
	input  wire                 nmi_pin_in,
	input  wire [5:0]           ext_request_n_in,
	input  wire [NUM_PER-1:0]   per_flag_in,
	input  wire [NUM_PER-1:0]   per_enable_in,
	input  wire                 core_mask_bit_in,
	input  wire [2:0]           core_mask_level_in,
	input  wire                 accept_in,
	input  wire [6:0]           accept_vector_in,
	output reg                  irq_request_out,
	output reg                  irq_nmi_out,
	output reg  [15:0]          irq_vector_addr_out,
	output reg  [2:0]           irq_level_out,
	output reg  [NUM_PER-1:0]   transfer_start_out,
	output reg                  wake_out
);

	localparam NC       = 6 + NUM_PER;
	localparam NFLD     = 16;
	localparam [23:0] PIN_FLD = {4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0};
	localparam [41:0] PIN_VEC = {7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10};

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg rst_s1_ff;
	reg rst_s2_ff;
	wire rst_n;

	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	assign rst_n = rst_s2_ff;

	// ----------------------------------------------------------------
	// software-visible state
	// ----------------------------------------------------------------
	reg        nmi_edge_ff;
	reg        ctrl_mode_ff;
	reg [11:0] pin_sense_config_ff;
	reg [5:0]  pin_request_enable_ff;
	reg [5:0]  pin_request_flags_ff;
	reg [5:0]  read_seen_ff;
	reg        nmi_pend_ff;
	reg [2:0]  pri_fld_ff [0:NFLD-1];

	// ----------------------------------------------------------------
	// pin detection, one instance per pin, nonmaskable at index 6
	// ----------------------------------------------------------------
	wire [6:0] pin_event;
	wire [6:0] pin_level;
	wire [6:0] pin_raw;
	wire [13:0] pin_sense;

	// port direction is not seen here: only the pin level arrives
	assign pin_raw   = {nmi_pin_in, ext_request_n_in}; // [RQ1] [RQ8]
	assign pin_sense = {(nmi_edge_ff ? `ISP_SENSE_RISE : `ISP_SENSE_FALL), // [RQ4]
	                    pin_sense_config_ff};

	genvar gp;
	generate
		for (gp = 0; gp < 7; gp = gp + 1) begin : g_pin
			isp_pin_detect u_det (
				.clk_in    (ref_clk_in),
				.rst_n_in  (rst_n),
				.pin_in    (pin_raw[gp]),
				.sense_in  (pin_sense[2*gp +: 2]),
				.event_out (pin_event[gp]),
				.level_out (pin_level[gp])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// bus slave: request seen while waitrequest high, done one edge later
	// ----------------------------------------------------------------
	wire        bus_req;
	wire        bus_done;
	wire        wr_done;
	wire        rd_done;
	wire [5:0]  word_sel;
	wire [15:0] wmask;
	wire [15:0] wdat;
	reg  [31:0] nxt_rdata;
	// one loop index per process: a shared index would retrigger the others
	integer     k;
	integer     kf;
	integer     ka;

	assign bus_req  = avs_read_in | avs_write_in;
	assign bus_done = bus_req & ~avs_waitrequest_out;
	assign wr_done  = bus_done & avs_write_in;
	assign rd_done  = bus_done & avs_read_in;
	assign word_sel = avs_address_in[7:2];
	assign wmask    = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wdat     = avs_writedata_in[15:0];

	wire sel_sys = (word_sel == `ISP_OFS_SYSCTL >> 2);
	wire sel_sns = (word_sel == `ISP_OFS_SENSE >> 2);
	wire sel_ena = (word_sel == `ISP_OFS_ENABLE >> 2);
	wire sel_flg = (word_sel == `ISP_OFS_FLAGS >> 2);
	wire sel_pri = (avs_address_in >= `ISP_OFS_PRI_BASE) &&
	               (avs_address_in <= `ISP_OFS_PRI_LAST);
	wire [2:0] pri_idx = avs_address_in[4:2] - 3'h4;

	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (sel_sys) begin
			nxt_rdata[`ISP_BIT_NMI_EDGE]  = nmi_edge_ff;
			nxt_rdata[`ISP_BIT_CTRL_MODE] = ctrl_mode_ff;
			nxt_rdata[`ISP_BIT_NMI_PEND]  = nmi_pend_ff;
		end else if (sel_sns) begin
			nxt_rdata[11:0] = pin_sense_config_ff;
		end else if (sel_ena) begin
			nxt_rdata[5:0] = pin_request_enable_ff;
		end else if (sel_flg) begin
			nxt_rdata[5:0] = pin_request_flags_ff;
		end else if (sel_pri) begin
			nxt_rdata[6:4] = pri_fld_ff[{pri_idx, 1'b0}];
			nxt_rdata[2:0] = pri_fld_ff[{pri_idx, 1'b1}];
		end
		// unmapped words read as zero, writes dropped
	end

	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else begin
			if (bus_req && avs_waitrequest_out) begin
				avs_waitrequest_out <= 1'b0;
				avs_readdata_out    <= nxt_rdata;
			end else begin
				avs_waitrequest_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			nmi_edge_ff           <= 1'b0; // [RQ22]
			ctrl_mode_ff          <= 1'b0; // [RQ22]
			pin_sense_config_ff   <= `ISP_RST_SENSE; // [RQ22]
			pin_request_enable_ff <= `ISP_RST_ENABLE; // [RQ22]
			for (k = 0; k < NFLD; k = k + 1) begin
				pri_fld_ff[k] <= `ISP_RST_PRI; // [RQ22]
			end
		end else if (wr_done) begin
			if (sel_sys && avs_byteenable_in[0]) begin
				nmi_edge_ff  <= wdat[`ISP_BIT_NMI_EDGE]; // [RQ4]
				ctrl_mode_ff <= wdat[`ISP_BIT_CTRL_MODE];
			end
			if (sel_sns) begin
				pin_sense_config_ff <= (pin_sense_config_ff & ~wmask[11:0]) |
				                       (wdat[11:0] & wmask[11:0]); // [RQ5]
			end
			if (sel_ena && avs_byteenable_in[0]) begin
				pin_request_enable_ff <= wdat[5:0]; // [RQ6]
			end
			if (sel_pri && avs_byteenable_in[0]) begin
				pri_fld_ff[{pri_idx, 1'b0}] <= wdat[6:4]; // [RQ11]
				pri_fld_ff[{pri_idx, 1'b1}] <= wdat[2:0]; // [RQ11]
			end
		end
	end

	// ----------------------------------------------------------------
	// pin flags: set wins over software and acceptance clears
	// ----------------------------------------------------------------
	reg  [5:0] nxt_flags;
	reg  [5:0] nxt_seen;
	reg  [5:0] sw_clr;
	reg  [5:0] acc_clr;
	reg        nxt_nmi_pend;

	always @* begin
		sw_clr  = 6'h00;
		acc_clr = 6'h00;
		nxt_seen = read_seen_ff;
		if (rd_done && sel_flg) begin
			nxt_seen = read_seen_ff | avs_readdata_out[5:0]; // [RQ18]
		end
		if (wr_done && sel_flg && avs_byteenable_in[0]) begin
			// a 0 write clears only a flag that was read as 1
			sw_clr   = read_seen_ff & ~wdat[5:0]; // [RQ7] [RQ18]
			nxt_seen = 6'h00;
		end
		for (kf = 0; kf < 6; kf = kf + 1) begin
			if (accept_in && (accept_vector_in == PIN_VEC[7*kf +: 7])) begin
				if (pin_sense_config_ff[2*kf +: 2] != `ISP_SENSE_LOW) begin
					acc_clr[kf] = 1'b1; // [RQ19]
				end else begin
					acc_clr[kf] = pin_level[kf]; // [RQ19]
				end
			end
		end
		nxt_flags = (pin_request_flags_ff & ~(sw_clr | acc_clr)) |
		            pin_event[5:0]; // [RQ7]
		nxt_nmi_pend = (nmi_pend_ff &
		                ~(accept_in && (accept_vector_in == `ISP_VEC_NMI))) |
		               pin_event[6];
	end

	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_request_flags_ff <= `ISP_RST_FLAGS; // [RQ22]
			read_seen_ff         <= 6'h00;
			nmi_pend_ff          <= 1'b0;
		end else begin
			pin_request_flags_ff <= nxt_flags;
			read_seen_ff         <= nxt_seen & nxt_flags;
			nmi_pend_ff          <= nxt_nmi_pend;
		end
	end

	// ----------------------------------------------------------------
	// candidate table in ascending vector order
	// ----------------------------------------------------------------
	wire [NC-1:0]   cand_req;
	wire [3*NC-1:0] cand_lvl;
	wire [7*NC-1:0] cand_vec;

	genvar gc;
	generate
		for (gc = 0; gc < NC; gc = gc + 1) begin : g_cand
			if (gc < 6) begin : g_pinc
				assign cand_req[gc] = pin_request_flags_ff[gc] &
				                      pin_request_enable_ff[gc]; // [RQ6]
				assign cand_lvl[3*gc +: 3] = pri_fld_ff[PIN_FLD[4*gc +: 4]]; // [RQ11]
				assign cand_vec[7*gc +: 7] = PIN_VEC[7*gc +: 7]; // [RQ16]
			end else begin : g_perc
				assign cand_req[gc] = per_flag_in[gc-6] & per_enable_in[gc-6]; // [RQ9]
				assign cand_lvl[3*gc +: 3] = pri_fld_ff[PER_FLD[4*(gc-6) +: 4]]; // [RQ11]
				assign cand_vec[7*gc +: 7] = PER_VEC[7*(gc-6) +: 7];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// arbitration: strict greater keeps the lower vector on a tie
	// ----------------------------------------------------------------
	reg       found;
	reg [2:0] best_lvl;
	reg [6:0] best_vec;
	reg [2:0] eff_lvl;
	reg       accept;
	reg [6:0] out_vec;
	reg [2:0] out_lvl;

	always @* begin
		found    = 1'b0;
		best_lvl = 3'h0;
		best_vec = 7'h00;
		eff_lvl  = 3'h0;
		for (ka = 0; ka < NC; ka = ka + 1) begin
			// control mode 0 flattens levels so only vector order counts
			eff_lvl = ctrl_mode_ff ? cand_lvl[3*ka +: 3] : 3'h0;
			if (cand_req[ka] && (!found || (eff_lvl > best_lvl))) begin // [RQ12] [RQ13] [RQ14]
				found    = 1'b1;
				best_lvl = eff_lvl;
				best_vec = cand_vec[7*ka +: 7];
			end
		end
		if (nmi_pend_ff) begin
			accept  = 1'b1; // [RQ3]
			out_vec = `ISP_VEC_NMI; // [RQ3]
			out_lvl = `ISP_LVL_NMI;
		end else begin
			out_vec = best_vec;
			out_lvl = best_lvl;
			if (ctrl_mode_ff) begin
				accept = found && (best_lvl > core_mask_level_in); // [RQ20]
			end else begin
				accept = found && !core_mask_bit_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs to the core and the transfer controller
	// ----------------------------------------------------------------
	always @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_request_out     <= 1'b0;
			irq_nmi_out         <= 1'b0;
			irq_vector_addr_out <= 16'h0000;
			irq_level_out       <= 3'h0;
			transfer_start_out  <= {NUM_PER{1'b0}};
			wake_out            <= 1'b0;
		end else begin
			irq_request_out     <= accept;
			irq_nmi_out         <= nmi_pend_ff; // [RQ3]
			irq_vector_addr_out <= accept ? {7'h00, out_vec, 2'b00} : 16'h0000; // [RQ15]
			irq_level_out       <= accept ? out_lvl : 3'h0;
			// no mask term here: transfers start on flag and enable alone
			transfer_start_out  <= per_flag_in & per_enable_in; // [RQ10]
			wake_out            <= nmi_pend_ff | (|pin_request_flags_ff); // [RQ2]
		end
	end

endmodule

// [bench/isp_top_monitor.sv]
module isp_top_monitor #(
	parameter NUM_PER = 10
) (
	input logic               ref_clk_in,
	input logic               rstn_in,
	input logic               avs_read_in,
	input logic               avs_write_in,
	input logic               avs_waitrequest_out,
	input logic [NUM_PER-1:0] per_flag_in,
	input logic [NUM_PER-1:0] per_enable_in,
	input logic               core_mask_bit_in,
	input logic [2:0]         core_mask_level_in,
	input logic               irq_request_out,
	input logic               irq_nmi_out,
	input logic [15:0]        irq_vector_addr_out,
	input logic [2:0]         irq_level_out,
	input logic [NUM_PER-1:0] transfer_start_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// handshake and request outputs
	// ----------------------------------------
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_taken;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_answer;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	a_bus_answer: assert property (s_taken |=> s_answer)
		else $error("bus access not answered in one cycle");
	a_wait_idle: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
		else $error("waitrequest low without a request");
	a_xfer_start: assert property (transfer_start_out == $past(per_flag_in & per_enable_in))
		else $error("transfer start not flag and enable");
	a_nmi_wins: assert property (irq_nmi_out |-> irq_request_out &&
		irq_vector_addr_out == 16'h001C && irq_level_out == 3'h7)
		else $error("nonmaskable pending but not presented");
	a_idle_zero: assert property (!irq_request_out |->
		irq_vector_addr_out == 16'h0000 && irq_level_out == 3'h0)
		else $error("vector or level shown while idle");
	a_vec_legal: assert property (irq_request_out |-> irq_vector_addr_out[1:0] == 2'h0 &&
		!(irq_vector_addr_out[15:2] inside {14'h0016, 14'h0017, 14'h0067}))
		else $error("reserved or unaligned vector");
	a_vec_order: assert property (irq_request_out && !irq_nmi_out |->
		irq_vector_addr_out >= 16'h0040)
		else $error("maskable vector below pin range");
	a_mask_level: assert property (irq_request_out && !irq_nmi_out && irq_level_out != 3'h0 |->
		irq_level_out > $past(core_mask_level_in))
		else $error("request not above mask level");
	a_mask_bit: assert property ($past(core_mask_bit_in) && irq_level_out == 3'h0 |->
		!irq_request_out)
		else $error("masked request presented");
endmodule

bind isp_top isp_top_monitor #(.NUM_PER(NUM_PER)) isp_top_monitor_inst (.ref_clk_in, .rstn_in,
	.avs_read_in, .avs_write_in, .avs_waitrequest_out, .per_flag_in, .per_enable_in,
	.core_mask_bit_in, .core_mask_level_in, .irq_request_out, .irq_nmi_out,
	.irq_vector_addr_out, .irq_level_out, .transfer_start_out);

// [bench/isp_core_model.sv]
module isp_core_model (
	input  logic        clk_in,
	input  logic        rstn_in,
	input  logic        en_in,
	input  logic [7:0]  delay_in,
	input  logic        request_in,
	input  logic [15:0] vector_addr_in,
	output logic        accept_out,
	output logic [6:0]  accept_vector_out,
	output logic [7:0]  accept_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] gap_ff;
	// ----------------------------------------
	// acceptance: one pulse, then a pause
	// ----------------------------------------
	// pause of at least two: request only drops one edge after the clear
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			accept_out <= 1'b0;
			accept_vector_out <= 7'h00;
			accept_count_out <= 8'h00;
			gap_ff <= 9'h000;
		end else if (gap_ff != 9'h000) begin
			accept_out <= 1'b0;
			accept_vector_out <= ~accept_vector_out;
			gap_ff <= gap_ff - 9'h001;
		end else if (en_in && request_in) begin
			accept_out <= 1'b1;
			accept_vector_out <= vector_addr_in[8:2];
			accept_count_out <= accept_count_out + 8'h01;
			gap_ff <= {1'b0, delay_in} + 9'h002;
		end else begin
			accept_out <= 1'b0;
			accept_vector_out <= ~accept_vector_out;
		end
	end
endmodule

// [bench/test_isp_top.sv]
module test_isp_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        nmi_pin_in = 1'b1;
	logic [5:0]  ext_request_n_in = 6'h3F;
	logic [9:0]  per_flag_in = 10'h000;
	logic [9:0]  per_enable_in = 10'h000;
	logic        core_mask_bit_in = 1'b0;
	logic [2:0]  core_mask_level_in = 3'h0;
	logic        accept_in;
	logic [6:0]  accept_vector_in;
	logic        irq_request_out;
	logic        irq_nmi_out;
	logic [15:0] irq_vector_addr_out;
	logic [2:0]  irq_level_out;
	logic [9:0]  transfer_start_out;
	logic        wake_out;
	logic        core_en = 1'b0;
	logic [7:0]  core_dly = 8'h00;
	logic [7:0]  n_acc;
	logic [31:0] rq;
	int          mismatches = 0;
	int          n_checks = 0;

	isp_top isp_top_inst (.ref_clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.nmi_pin_in, .ext_request_n_in, .per_flag_in, .per_enable_in, .core_mask_bit_in,
		.core_mask_level_in, .accept_in, .accept_vector_in, .irq_request_out, .irq_nmi_out,
		.irq_vector_addr_out, .irq_level_out, .transfer_start_out, .wake_out);
	isp_core_model isp_core_model_inst (.clk_in(ref_clk_in), .rstn_in(rstn_in), .en_in(core_en),
		.delay_in(core_dly), .request_in(irq_request_out), .vector_addr_in(irq_vector_addr_out),
		.accept_out(accept_in), .accept_vector_out(accept_vector_in), .accept_count_out(n_acc));

	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
			mismatches++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// held until waitrequest is sampled low; bounded against a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= d;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		rq = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge ref_clk_in);
		if (n >= 20) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rq, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'h0);
		rdchk(8'h0C, 32'h0);
		rdchk(8'h10, 32'h77);
		bus(1'b1, 8'h30, 32'hFFFF);
		rdchk(8'h30, 32'h0);
	endtask
	// per code: flag after fall, then after rise; level keeps flag while low
	task automatic t_sense();
		logic [3:0] e1;
		logic [3:0] e2;
		e1 = 4'hB;
		e2 = 4'hD;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'h04, c);
			ext_request_n_in[0] <= 1'b0;
			cyc(6);
			rdchk(8'h0C, {31'h0, e1[c]});
			chk("wake", 32'(wake_out), {31'h0, e1[c]});
			bus(1'b1, 8'h0C, 32'h0);
			ext_request_n_in[0] <= 1'b1;
			cyc(6);
			rdchk(8'h0C, {31'h0, e2[c]});
			bus(1'b1, 8'h0C, 32'h0);
			rdchk(8'h0C, 32'h0);
		end
	endtask
	task automatic t_clear_read();
		bus(1'b1, 8'h04, 32'h1);
		ext_request_n_in[0] <= 1'b0;
		cyc(6);
		ext_request_n_in[0] <= 1'b1;
		bus(1'b1, 8'h0C, 32'h0);
		rdchk(8'h0C, 32'h1);
		bus(1'b1, 8'h0C, 32'h0);
		rdchk(8'h0C, 32'h0);
	endtask
	task automatic t_prio();
		bus(1'b1, 8'h04, 32'h5);
		bus(1'b1, 8'h08, 32'h3);
		ext_request_n_in[1:0] <= 2'h0;
		cyc(6);
		ext_request_n_in[1:0] <= 2'h3;
		chk("vec pin0", 32'(irq_vector_addr_out), 32'h40);
		core_mask_bit_in <= 1'b1;
		cyc(3);
		chk("masked", 32'(irq_request_out), 32'h0);
		core_mask_bit_in <= 1'b0;
		bus(1'b1, 8'h00, 32'h2);
		bus(1'b1, 8'h10, 32'h35);
		cyc(3);
		chk("vec pin1", 32'(irq_vector_addr_out), 32'h44);
		chk("level", 32'(irq_level_out), 32'h5);
		core_mask_level_in <= 3'h4;
		cyc(3);
		chk("above mask", 32'(irq_request_out), 32'h1);
		core_mask_level_in <= 3'h5;
		cyc(3);
		chk("at mask", 32'(irq_request_out), 32'h0);
		core_mask_level_in <= 3'h0;
		bus(1'b1, 8'h10, 32'h44);
		cyc(3);
		chk("tie", 32'(irq_vector_addr_out), 32'h40);
		bus(1'b1, 8'h08, 32'h2);
		cyc(3);
		chk("disabled", 32'(irq_vector_addr_out), 32'h44);
		bus(1'b1, 8'h08, 32'h0);
		rdchk(8'h0C, 32'h3);
		bus(1'b1, 8'h0C, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
	endtask
	task automatic t_periph();
		core_mask_bit_in <= 1'b1;
		per_flag_in <= 10'h003;
		per_enable_in <= 10'h001;
		cyc(3);
		chk("xfer", 32'(transfer_start_out), 32'h1);
		chk("masked", 32'(irq_request_out), 32'h0);
		core_mask_bit_in <= 1'b0;
		per_enable_in <= 10'h002;
		cyc(3);
		chk("vec per1", 32'(irq_vector_addr_out), 32'h64);
		per_flag_in <= 10'h300;
		per_enable_in <= 10'h3FF;
		cyc(3);
		chk("vec module", 32'(irq_vector_addr_out), 32'h8C);
		per_flag_in <= 10'h000;
		per_enable_in <= 10'h000;
		cyc(3);
	endtask
	task automatic t_nmi();
		core_mask_bit_in <= 1'b1;
		bus(1'b1, 8'h00, 32'h1);
		nmi_pin_in <= 1'b0;
		cyc(6);
		chk("nmi fall", 32'(irq_nmi_out), 32'h0);
		nmi_pin_in <= 1'b1;
		cyc(6);
		chk("nmi", 32'(irq_nmi_out), 32'h1);
		chk("nmi vec", 32'(irq_vector_addr_out), 32'h1C);
		chk("wake", 32'(wake_out), 32'h1);
		core_en <= 1'b1;
		cyc(8);
		chk("nmi taken", 32'(irq_nmi_out), 32'h0);
		core_en <= 1'b0;
		bus(1'b1, 8'h00, 32'h0);
		nmi_pin_in <= 1'b0;
		cyc(6);
		chk("nmi fall sel", 32'(irq_nmi_out), 32'h1);
		core_en <= 1'b1;
		cyc(8);
		chk("nmi retaken", 32'(irq_nmi_out), 32'h0);
		core_en <= 1'b0;
		nmi_pin_in <= 1'b1;
		cyc(6);
		chk("nmi rise", 32'(irq_nmi_out), 32'h0);
		core_mask_bit_in <= 1'b0;
	endtask
	task automatic t_accept();
		logic [7:0] base;
		base = n_acc;
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b1, 8'h08, 32'h1);
		core_en <= 1'b1;
		core_dly <= 8'h05;
		ext_request_n_in[0] <= 1'b0;
		cyc(4);
		ext_request_n_in[0] <= 1'b1;
		cyc(12);
		rdchk(8'h0C, 32'h0);
		chk("accepts", 32'(n_acc), 32'(base) + 32'h1);
		// level sense: acceptance leaves the flag while the pin is low
		bus(1'b1, 8'h04, 32'h0);
		ext_request_n_in[0] <= 1'b0;
		cyc(12);
		rdchk(8'h0C, 32'h1);
		ext_request_n_in[0] <= 1'b1;
		cyc(14);
		rdchk(8'h0C, 32'h0);
		core_en <= 1'b0;
		bus(1'b1, 8'h08, 32'h0);
	endtask

	initial begin
		cyc(2);
		rstn_in <= 1'b1;
		cyc(3);
		t_reset();
		t_sense();
		t_clear_read();
		t_prio();
		t_periph();
		t_nmi();
		t_accept();
		test_done();
	end
endmodule
